// File: core/dbtr_pkg.sv
// Shared constants and carrier types for the debug breakpoint and trace block
package dbtr_pkg;

  // Sizes of the trace store
  localparam int unsigned DBTR_WORD_W     = 16;
  localparam int unsigned DBTR_FIFO_DEPTH = 8;

  // Offsets of the normally mapped registers, relative to the block's base
  localparam logic [2:0] DBTR_OFF_CMP_A_HIGH = 3'h0;
  localparam logic [2:0] DBTR_OFF_CMP_A_LOW  = 3'h1;
  localparam logic [2:0] DBTR_OFF_CMP_B_HIGH = 3'h2;
  localparam logic [2:0] DBTR_OFF_CMP_B_LOW  = 3'h3;
  localparam logic [2:0] DBTR_OFF_FIFO_HIGH  = 3'h4;
  localparam logic [2:0] DBTR_OFF_FIFO_LOW   = 3'h5;
  localparam logic [2:0] DBTR_OFF_CONTROL    = 3'h6;
  localparam logic [2:0] DBTR_OFF_FORCE_RST  = 3'h7;

  // Values after reset, and fixed read values
  localparam logic [7:0]  DBTR_CMP_RST       = 8'h00;
  localparam logic [7:0]  DBTR_CTRL_RST      = 8'h00;
  localparam logic [15:0] DBTR_BKPT_RST      = 16'h0000;
  localparam logic [7:0]  DBTR_FORCE_RD      = 8'h00;
  localparam logic [7:0]  DBTR_ZERO_BYTE     = 8'h00;

  // Field positions in the trace control register
  localparam int unsigned DBTR_CTRL_ENABLE   = 7;
  localparam int unsigned DBTR_CTRL_ARM      = 6;
  localparam int unsigned DBTR_CTRL_TAG      = 5;
  localparam int unsigned DBTR_CTRL_BREAK_REQUEST_ENABLE    = 4;
  localparam int unsigned DBTR_CTRL_RWA      = 3;
  localparam int unsigned DBTR_CTRL_COMP_A_DIRECTION_ENABLE    = 2;
  localparam int unsigned DBTR_CTRL_RWB      = 1;
  localparam int unsigned DBTR_CTRL_COMP_B_DIRECTION_ENABLE    = 0;

  // Field position of the forced reset bit
  localparam int unsigned DBTR_FORCE_BIT     = 0;

  // One processor bus cycle as seen by the comparators
  typedef struct packed {
    logic [15:0] addr;   // Address of the cycle
    logic [7:0]  data;   // Data byte of the cycle
    logic        read;   // High for a read cycle
    logic        fetch;  // High for an opcode fetch
    logic        valid;  // Cycle present this clock
  } dbtr_cpu_cycle_type;

  // One access to the normally mapped registers
  typedef struct packed {
    logic [2:0] offset;    // Register offset
    logic [7:0] wdata;     // Write data
    logic       wr;        // Write strobe, one cycle
    logic       rd;        // Read strobe, one cycle
    logic       from_host; // Access issued by a serial background command
  } dbtr_reg_req_type;

endpackage

// File: core/dbtr_top.sv
// Debug breakpoint match, forced reset and trace capture logic with its trace store
`timescale 1ns/100ps
`default_nettype none

// Shift-register store: entry 0 is the head, pops shift every entry down by one
module dbtr_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,     // System clock
  input  wire logic             nrst,      // Synchronous reset, active low
  input  wire logic             flush,     // Empty the store
  input  wire logic             in_valid,  // Word offered
  input  wire logic [WIDTH-1:0] in_data,   // Word to store
  output logic                  in_ready,  // Store can take the word
  output logic                  out_valid, // Head word present
  output logic [WIDTH-1:0]      out_data,  // Head word
  input  wire logic             out_ready, // Drain the head word
  output logic                  full,      // All entries hold data
  output logic                  empty      // No entry holds data
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  // Depth below two leaves nothing to shift
  if (DEPTH < 2) begin : g_depth_check
    $error("dbtr_fifo: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    wr_idx;
  logic             push;
  logic             pop;

  // Handshake decode
  assign full      = (count_q == CW'(DEPTH));
  assign empty     = (count_q == '0);
  assign out_valid = !empty;
  assign pop       = out_valid && out_ready;
  assign in_ready  = !full || pop;   // A pop frees the tail in the same cycle
  assign push      = in_valid && in_ready;
  assign wr_idx    = count_q - CW'(pop);
  assign count_d   = count_q + CW'(push) - CW'(pop);
  assign out_data  = mem_q[0];

  // Occupancy count
  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // One entry per loop step: load, shift down, or hold
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge clock) begin
      if (!nrst || flush) begin
        mem_q[g] <= '0;
      end else if (push && (wr_idx == CW'(g))) begin
        mem_q[g] <= in_data;
      end else if (pop && (g < DEPTH - 1)) begin
        mem_q[g] <= mem_q[(g < DEPTH - 1) ? g + 1 : g];
      end
    end
  end

endmodule // dbtr_fifo

// Functional notes
// - Sixteen-bit breakpoint match register holds the serial controller breakpoint address.
// - Breakpoint register reached only by breakpoint read and write commands.
// - Breakpoint enable and force/mark select bits configure breakpoint logic.
// - Forced reset register accepts writes only from serial background commands.
// - Reads of the forced reset register always return zero.
// - Host writing one to bit 0 forces a full MCU reset.
// - Block maps three 16-bit and two 8-bit (control, forced reset) registers for software.
// - Each comparator value is built from its own high and low byte.
// - Comparator bytes reset to zero, always readable, writable only while unarmed.
// - FIFO high byte register is read-only upper eight bits of current word.
// - FIFO low byte register is read-only lower eight bits of current word.
// - Event-only modes store data in low byte; high byte reads zero.
// - Reading FIFO high byte leaves the FIFO position unchanged.
// - Reading FIFO low byte advances the FIFO to the next word once all entries hold data.
// - While armed, low byte reads do not advance; reader waits for completion.
// - Unarmed low byte read stores last fetched opcode address at FIFO tail.
// - Unarmed profiling: ninth read returns what the first read stored.
// - Control register always accessible, resets to zero, fixed eight-field layout.
// - Write with enable and arm set arms capture and flag; completion or any other control write ends the run.
// - Force match requests a break; mark match tags the fetched opcode.
// - With breakpoint enable clear, select bit and match register are ignored.
module dbtr_top #(
  parameter int unsigned FIFO_DEPTH = dbtr_pkg::DBTR_FIFO_DEPTH
) (
  input  wire logic                         clock,                       // 100 MHz clock
  input  wire logic                         nrst,                        // Sync reset, low
  input  wire dbtr_pkg::dbtr_reg_req_type   reg_req,                     // Mapped access
  output logic [7:0]                        reg_rdata,                   // Read data
  input  wire logic                         write_breakpoint_command,    // Load match reg
  input  wire logic                         read_breakpoint_command,     // Read match reg
  input  wire logic [15:0]                  bkpt_wdata,                  // Match reg data
  output logic [15:0]                       bkpt_rdata,                  // Match reg readback
  input  wire logic                         breakpoint_enable_bit,       // From status reg
  input  wire logic                         force_or_mark_select,        // From status reg
  input  wire dbtr_pkg::dbtr_cpu_cycle_type cpu_cycle,                   // CPU bus cycle
  input  wire logic                         event_only_mode,             // Byte capture mode
  output logic                              capture_primed_flag,         // Run in progress
  output logic                              break_force,                 // Force break pulse
  output logic                              break_tag,                   // Tag opcode pulse
  output logic                              forced_reset_req,            // MCU reset pulse
  output logic                              capture_stall                // Capture refused
);

  localparam int unsigned W = dbtr_pkg::DBTR_WORD_W;

  // Register state
  logic [15:0] bkpt_q;
  logic [15:0] bkpt_rdata_q;
  logic [7:0]  cmp_a_high_q;
  logic [7:0]  cmp_a_low_q;
  logic [7:0]  cmp_b_high_q;
  logic [7:0]  cmp_b_low_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        primed_q;
  logic        primed_d;
  logic [7:0]  rdata_q;
  logic [15:0] last_fetch_q;
  logic        brk_force_q;
  logic        brk_tag_q;
  logic        force_rst_q;

  // Control fields
  logic trace_module_enable;
  logic capture_armed;
  logic mark_type_break;
  logic break_request_enable;
  logic comp_a_direction_value;
  logic comp_a_direction_enable;
  logic comp_b_direction_value;
  logic comp_b_direction_enable;

  assign trace_module_enable     = ctrl_q[dbtr_pkg::DBTR_CTRL_ENABLE];
  assign capture_armed           = ctrl_q[dbtr_pkg::DBTR_CTRL_ARM];
  assign mark_type_break         = ctrl_q[dbtr_pkg::DBTR_CTRL_TAG];
  assign break_request_enable    = ctrl_q[dbtr_pkg::DBTR_CTRL_BREAK_REQUEST_ENABLE];
  assign comp_a_direction_value  = ctrl_q[dbtr_pkg::DBTR_CTRL_RWA];
  assign comp_a_direction_enable = ctrl_q[dbtr_pkg::DBTR_CTRL_COMP_A_DIRECTION_ENABLE];
  assign comp_b_direction_value  = ctrl_q[dbtr_pkg::DBTR_CTRL_RWB];
  assign comp_b_direction_enable = ctrl_q[dbtr_pkg::DBTR_CTRL_COMP_B_DIRECTION_ENABLE];

  // Address decode of the mapped registers
  logic sel_cmp_a_high;
  logic sel_cmp_a_low;
  logic sel_cmp_b_high;
  logic sel_cmp_b_low;
  logic sel_fifo_high;
  logic sel_fifo_low;
  logic sel_control;
  logic sel_force_rst;

  assign sel_cmp_a_high = (reg_req.offset == dbtr_pkg::DBTR_OFF_CMP_A_HIGH);
  assign sel_cmp_a_low  = (reg_req.offset == dbtr_pkg::DBTR_OFF_CMP_A_LOW);
  assign sel_cmp_b_high = (reg_req.offset == dbtr_pkg::DBTR_OFF_CMP_B_HIGH);
  assign sel_cmp_b_low  = (reg_req.offset == dbtr_pkg::DBTR_OFF_CMP_B_LOW);
  assign sel_fifo_high  = (reg_req.offset == dbtr_pkg::DBTR_OFF_FIFO_HIGH);
  assign sel_fifo_low   = (reg_req.offset == dbtr_pkg::DBTR_OFF_FIFO_LOW);
  assign sel_control    = (reg_req.offset == dbtr_pkg::DBTR_OFF_CONTROL);
  assign sel_force_rst  = (reg_req.offset == dbtr_pkg::DBTR_OFF_FORCE_RST);

  // Write qualifiers; comparator bytes freeze for the whole armed run
  logic cmp_wr_ok;
  logic ctrl_wr;
  logic force_wr;
  logic arm_write;
  logic stop_write;

  assign cmp_wr_ok  = reg_req.wr && !capture_armed;
  assign ctrl_wr    = reg_req.wr && sel_control;
  assign force_wr   = reg_req.wr && sel_force_rst && reg_req.from_host;
  assign arm_write  = ctrl_wr && reg_req.wdata[dbtr_pkg::DBTR_CTRL_ARM]
                      && reg_req.wdata[dbtr_pkg::DBTR_CTRL_ENABLE];
  assign stop_write = ctrl_wr && !arm_write;

  // Comparators; the direction check is skipped unless enabled
  logic [15:0] cmp_a_value;
  logic [15:0] cmp_b_value;
  logic        cmp_a_hit;
  logic        cmp_b_hit;
  logic        trigger;

  assign cmp_a_value = {cmp_a_high_q, cmp_a_low_q};
  assign cmp_b_value = {cmp_b_high_q, cmp_b_low_q};
  assign cmp_a_hit   = cpu_cycle.valid && (cpu_cycle.addr == cmp_a_value)
                       && (!comp_a_direction_enable
                           || (cpu_cycle.read == comp_a_direction_value));
  assign cmp_b_hit   = cpu_cycle.valid && (cpu_cycle.addr == cmp_b_value)
                       && (!comp_b_direction_enable
                           || (cpu_cycle.read == comp_b_direction_value));
  assign trigger     = trace_module_enable && capture_armed && (cmp_a_hit || cmp_b_hit);

  // Trace store handshake
  logic         fifo_in_valid;
  logic [W-1:0] fifo_in_data;
  logic         fifo_in_ready;
  logic [W-1:0] fifo_out_data;
  logic         fifo_out_ready;
  logic         fifo_full;
  logic         low_read;
  logic         profile_read;
  logic [W-1:0] capture_word;
  logic         run_done;

  assign low_read     = reg_req.rd && sel_fifo_low;
  assign profile_read = low_read && !capture_armed;
  // Event-only runs keep just the data byte, upper half forced to zero
  assign capture_word = event_only_mode ? {dbtr_pkg::DBTR_ZERO_BYTE, cpu_cycle.data}
                                        : cpu_cycle.addr;
  assign fifo_in_valid = capture_armed ? trigger : profile_read;
  assign fifo_in_data  = capture_armed ? capture_word : last_fetch_q;
  // Reads drain only once all eight slots hold data, so the eight-read delay holds
  // Only low-byte reads drain; a high-byte read leaves the head in place
  assign fifo_out_ready = profile_read && fifo_full;
  assign run_done       = capture_armed && fifo_full;
  assign capture_stall  = fifo_in_valid && !fifo_in_ready;

  dbtr_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_trace_store (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (arm_write),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready),
    .full      (fifo_full),
    .empty     ()
  );

  // Read data selection; write-only and unused bits read as zero
  logic [7:0] fifo_high_byte;
  logic [7:0] rd_mux;

  assign fifo_high_byte = event_only_mode ? dbtr_pkg::DBTR_ZERO_BYTE
                                          : fifo_out_data[15:8];
  assign rd_mux = sel_cmp_a_high ? cmp_a_high_q :
                  sel_cmp_a_low  ? cmp_a_low_q :
                  sel_cmp_b_high ? cmp_b_high_q :
                  sel_cmp_b_low  ? cmp_b_low_q :
                  sel_fifo_high  ? fifo_high_byte :
                  sel_fifo_low   ? fifo_out_data[7:0] :
                  sel_control    ? ctrl_q :
                                   dbtr_pkg::DBTR_FORCE_RD;

  // Next control value: a fresh arm wins over completion in the same cycle
  always_comb begin
    ctrl_d   = ctrl_q;
    primed_d = primed_q;
    if (run_done) begin
      ctrl_d[dbtr_pkg::DBTR_CTRL_ARM] = 1'b0;
      primed_d                        = 1'b0;
    end
    if (ctrl_wr) begin
      ctrl_d = reg_req.wdata;
      ctrl_d[dbtr_pkg::DBTR_CTRL_ARM] = arm_write;
      primed_d = arm_write;
    end
    if (stop_write) begin
      primed_d = 1'b0;
    end
  end

  // Control register and primed flag
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q   <= dbtr_pkg::DBTR_CTRL_RST;
      primed_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      primed_q <= primed_d;
    end
  end

  // Comparator bytes
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmp_a_high_q <= dbtr_pkg::DBTR_CMP_RST;
      cmp_a_low_q  <= dbtr_pkg::DBTR_CMP_RST;
      cmp_b_high_q <= dbtr_pkg::DBTR_CMP_RST;
      cmp_b_low_q  <= dbtr_pkg::DBTR_CMP_RST;
    end else if (cmp_wr_ok) begin
      if (sel_cmp_a_high) cmp_a_high_q <= reg_req.wdata;
      if (sel_cmp_a_low)  cmp_a_low_q  <= reg_req.wdata;
      if (sel_cmp_b_high) cmp_b_high_q <= reg_req.wdata;
      if (sel_cmp_b_low)  cmp_b_low_q  <= reg_req.wdata;
    end
  end

  // Registered read data, valid the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= dbtr_pkg::DBTR_ZERO_BYTE;
    end else if (reg_req.rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Address of the most recent opcode fetch, fed in by profiling reads
  always_ff @(posedge clock) begin
    if (!nrst) begin
      last_fetch_q <= dbtr_pkg::DBTR_BKPT_RST;
    end else if (cpu_cycle.valid && cpu_cycle.fetch) begin
      last_fetch_q <= cpu_cycle.addr;
    end
  end

  // Breakpoint match register, only reachable by the dedicated commands
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bkpt_q       <= dbtr_pkg::DBTR_BKPT_RST;
      bkpt_rdata_q <= dbtr_pkg::DBTR_BKPT_RST;
    end else begin
      if (write_breakpoint_command) bkpt_q <= bkpt_wdata;
      if (read_breakpoint_command)  bkpt_rdata_q <= bkpt_q;
    end
  end

  // Breakpoint compare; disabled breakpoint ignores the select and the address
  logic bkpt_hit;
  logic bkpt_force_req;
  logic bkpt_tag_req;
  logic trace_force_req;
  logic trace_tag_req;

  assign bkpt_hit        = breakpoint_enable_bit && cpu_cycle.valid
                           && (cpu_cycle.addr == bkpt_q);
  assign bkpt_force_req  = bkpt_hit && force_or_mark_select;
  // Only an opcode fetch can be tagged; the CPU decides if it executes
  assign bkpt_tag_req    = bkpt_hit && !force_or_mark_select && cpu_cycle.fetch;
  assign trace_force_req = run_done && break_request_enable && !mark_type_break;
  assign trace_tag_req   = run_done && break_request_enable && mark_type_break;

  // One-cycle break pulses and the forced reset pulse
  always_ff @(posedge clock) begin
    if (!nrst) begin
      brk_force_q <= 1'b0;
      brk_tag_q   <= 1'b0;
      force_rst_q <= 1'b0;
    end else begin
      brk_force_q <= bkpt_force_req || trace_force_req;
      brk_tag_q   <= bkpt_tag_req || trace_tag_req;
      force_rst_q <= force_wr && reg_req.wdata[dbtr_pkg::DBTR_FORCE_BIT];
    end
  end

  // Outputs, all from flip-flops except capture_stall
  assign reg_rdata           = rdata_q;
  assign bkpt_rdata          = bkpt_rdata_q;
  assign capture_primed_flag = primed_q;
  assign break_force         = brk_force_q;
  assign break_tag           = brk_tag_q;
  assign forced_reset_req    = force_rst_q;

endmodule // dbtr_top

`default_nettype wire

// File: testbench/dbtr_top_props.sv
// Port checker for the debug breakpoint and trace block
`timescale 1ns/100ps
`default_nettype none
module dbtr_top_props #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic                         clock,                    // Clock
  input wire logic                         nrst,                     // Reset, low
  input wire dbtr_pkg::dbtr_reg_req_type   reg_req,                  // Access
  input wire logic [7:0]                   reg_rdata,                // Read data
  input wire logic                         write_breakpoint_command, // Load
  input wire logic                         read_breakpoint_command,  // Read
  input wire logic [15:0]                  bkpt_wdata,               // Load data
  input wire logic [15:0]                  bkpt_rdata,               // Readback
  input wire logic                         breakpoint_enable_bit,    // Enable
  input wire logic                         force_or_mark_select,     // Select
  input wire dbtr_pkg::dbtr_cpu_cycle_type cpu_cycle,                // Bus cycle
  input wire logic                         event_only_mode,          // Byte mode
  input wire logic                         capture_primed_flag,      // Primed
  input wire logic                         break_force,              // Force
  input wire logic                         break_tag,                // Tag
  input wire logic                         forced_reset_req,         // Reset pulse
  input wire logic                         capture_stall             // Refused
);
  logic [15:0] bkpt_q; // Shadow of the match register
  logic        fr_wr;  // Host write of the reset bit
  logic        ctl_wr; // Control write
  // Decodes of the requests that have fixed answers
  assign fr_wr  = reg_req.wr && reg_req.from_host && reg_req.offset == 3'h7 && reg_req.wdata[0];
  assign ctl_wr = reg_req.wr && reg_req.offset == 3'h6;
  // Shadow kept here so hits are judged without peeking inside
  always_ff @(posedge clock) begin
    if (!nrst) bkpt_q <= 16'h0000;
    else if (write_breakpoint_command) bkpt_q <= bkpt_wdata;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  fr_pulse_a: assert property (fr_wr |=> forced_reset_req)
    else $error("forced reset pulse missing");
  fr_cause_a: assert property (forced_reset_req |-> $past(fr_wr))
    else $error("forced reset without host write");
  fr_read_a: assert property (reg_req.rd && reg_req.offset == 3'h7 |=> reg_rdata == 8'h00)
    else $error("forced reset register read not zero");
  bkpt_rd_a: assert property (read_breakpoint_command && !write_breakpoint_command
    |=> bkpt_rdata == $past(bkpt_q))
    else $error("match register readback wrong");
  brk_hit_a: assert property (cpu_cycle.valid && breakpoint_enable_bit && force_or_mark_select
    && cpu_cycle.addr == bkpt_q && !write_breakpoint_command |=> break_force)
    else $error("force break missing");
  brk_off_a: assert property (!breakpoint_enable_bit && !capture_primed_flag
    |=> !break_force && !break_tag)
    else $error("break while breakpoint disabled");
  ev_high_a: assert property (reg_req.rd && reg_req.offset == 3'h4 && event_only_mode
    |=> reg_rdata == 8'h00)
    else $error("byte mode high read not zero");
  arm_set_a: assert property (ctl_wr && reg_req.wdata[7:6] == 2'b11 |=> capture_primed_flag)
    else $error("arm write did not prime");
  arm_stop_a: assert property (ctl_wr && reg_req.wdata[7:6] != 2'b11
    |=> !capture_primed_flag)
    else $error("stop write left primed");
  stall_arm_a: assert property (capture_stall |-> capture_primed_flag)
    else $error("store refused a word while unarmed");
endmodule // dbtr_top_props
bind dbtr_top dbtr_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) dbtr_top_props_inst (
  .clock(clock), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .write_breakpoint_command(write_breakpoint_command),
  .read_breakpoint_command(read_breakpoint_command), .bkpt_wdata(bkpt_wdata),
  .bkpt_rdata(bkpt_rdata), .breakpoint_enable_bit(breakpoint_enable_bit),
  .force_or_mark_select(force_or_mark_select), .cpu_cycle(cpu_cycle),
  .event_only_mode(event_only_mode), .capture_primed_flag(capture_primed_flag),
  .break_force(break_force), .break_tag(break_tag), .forced_reset_req(forced_reset_req),
  .capture_stall(capture_stall));
`default_nettype wire

// File: testbench/dbtr_cpu_model.sv
// Processor bus model issuing one bus cycle per request
`timescale 1ns/100ps
`default_nettype none
module dbtr_cpu_model (
  input wire logic                  clock, // Clock
  input wire logic                  fire,  // Issue a cycle
  input wire logic                  fetch, // Cycle is an opcode fetch
  input wire logic [15:0]           addr,  // Cycle address
  output dbtr_pkg::dbtr_cpu_cycle_type cyc // Bus cycle
);
  initial cyc = '0;
  // Idle bus toggles, so a stale address never looks like a hit
  always @(posedge clock) begin
    cyc.valid <= fire;
    cyc.fetch <= fire & fetch;
    cyc.read  <= 1'b1;
    cyc.addr  <= fire ? addr : ~cyc.addr;
    cyc.data  <= fire ? addr[7:0] : ~cyc.data;
  end
endmodule // dbtr_cpu_model
`default_nettype wire

// File: testbench/dbtr_top_bench.sv
// Self-checking bench for the debug breakpoint and trace block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dbtr_top_bench;
  logic                         clock = 1'b0;
  logic                         nrst  = 1'b0;
  dbtr_pkg::dbtr_reg_req_type   req   = '0;
  dbtr_pkg::dbtr_cpu_cycle_type cyc;
  logic [7:0]                   rdata, got;
  logic [15:0]                  bk_wd = 16'h0000, bk_rd, addr = 16'h0000;
  logic                         wbk = 1'b0, rbk = 1'b0, bk_en = 1'b0, bk_sel = 1'b0;
  logic                         ev = 1'b0, fire = 1'b0, fetch = 1'b0;
  logic                         primed, brk_f, brk_t, frr, stall;
  int                           error_cnt = 0, n_checks = 0, cyc_cnt = 0;
  always #5 clock = ~clock;
  dbtr_cpu_model dbtr_cpu_model_inst (.clock(clock), .fire(fire), .fetch(fetch),
    .addr(addr), .cyc(cyc));
  dbtr_top dbtr_top_inst (.clock(clock), .nrst(nrst), .reg_req(req), .reg_rdata(rdata),
    .write_breakpoint_command(wbk), .read_breakpoint_command(rbk), .bkpt_wdata(bk_wd),
    .bkpt_rdata(bk_rd), .breakpoint_enable_bit(bk_en), .force_or_mark_select(bk_sel),
    .cpu_cycle(cyc), .event_only_mode(ev), .capture_primed_flag(primed),
    .break_force(brk_f), .break_tag(brk_t), .forced_reset_req(frr), .capture_stall(stall));
  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the 162 cycles the run needs
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  // Register access: strobe for one edge, answer after that edge
  task automatic wr(input logic [2:0] o, input logic [7:0] d, input logic h);
    @(posedge clock);
    req <= '{o, d, 1'b1, 1'b0, h};
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] o);
    @(posedge clock);
    req <= '{o, 8'h00, 1'b0, 1'b1, 1'b0};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic bkcmd(input logic w, input logic [15:0] d);
    @(posedge clock);
    wbk <= w;
    rbk <= !w;
    bk_wd <= d;
    @(posedge clock);
    wbk <= 1'b0;
    rbk <= 1'b0;
    #1;
  endtask
  // One bus cycle; break outputs are settled when this returns
  task automatic cpu(input logic [15:0] a, input logic f, input logic en, input logic s);
    @(posedge clock);
    fire <= 1'b1;
    fetch <= f;
    addr <= a;
    bk_en <= en;
    bk_sel <= s;
    @(posedge clock);
    fire <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i != 5) rd(3'(i));
      if (i != 5) `CHK("reset value", 8'h00, got)
    end
    for (int i = 0; i < 4; i++) wr(3'(i), 8'(8'h11 * (i + 1)), 1'b0);
    wr(3'h4, 8'hff, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rd(3'(i));
      `CHK("readback", (i == 4) ? 8'h00 : 8'(8'h11 * (i + 1)), got)
    end
    wr(3'h6, 8'h3f, 1'b0);
    rd(3'h6);
    `CHK("control", 8'h3f, got)
    wr(3'h6, 8'hc0, 1'b0);
    `CHK("primed", 1'b1, primed)
    wr(3'h0, 8'hff, 1'b0);
    rd(3'h0);
    `CHK("locked cmp", 8'h11, got)
    wr(3'h6, 8'h00, 1'b0);
    `CHK("stopped", 1'b0, primed)
    wr(3'h7, 8'h01, 1'b0);
    `CHK("user reset", 1'b0, frr)
    wr(3'h7, 8'h01, 1'b1);
    `CHK("host reset", 1'b1, frr)
    rd(3'h7);
    `CHK("reset reg", 8'h00, got)
    bkcmd(1'b1, 16'h4321);
    bkcmd(1'b0, 16'h0000);
    `CHK("match reg", 16'h4321, bk_rd)
    cpu(16'h4321, 1'b0, 1'b1, 1'b1);
    `CHK("force", 1'b1, brk_f)
    cpu(16'h4321, 1'b1, 1'b1, 1'b0);
    `CHK("tag", 1'b1, brk_t)
    cpu(16'h4321, 1'b1, 1'b0, 1'b1);
    `CHK("disabled", 1'b0, brk_f | brk_t)
    // Profiling: eight priming reads, the ninth shows the first fetch
    for (int i = 0; i < 9; i++) begin
      cpu(16'(16'ha530 + i * 16'h0101), 1'b1, 1'b0, 1'b0);
      if (i == 8) rd(3'h4);
      if (i == 8) `CHK("prof high", 8'ha5, got)
      if (i == 8) rd(3'h4);
      if (i == 8) `CHK("high again", 8'ha5, got)
      rd(3'h5);
    end
    `CHK("prof low", 8'h30, got)
    @(posedge clock);
    ev <= 1'b1;
    rd(3'h4);
    `CHK("byte high", 8'h00, got)
    // Armed byte capture on both comparators; an early read must not drain
    wr(3'h6, 8'hd0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cpu(i[0] ? 16'h3344 : 16'h1122, 1'b0, 1'b0, 1'b0);
      if (i == 0) rd(3'h5);
      if (i == 0) `CHK("armed read", 8'h22, got)
    end
    @(posedge clock);
    #1;
    `CHK("run break", 1'b1, brk_f)
    `CHK("run done", 1'b0, primed)
    rd(3'h5);
    `CHK("first word", 8'h22, got)
    rd(3'h5);
    `CHK("second word", 8'h44, got)
    test_done();
  end
endmodule // dbtr_top_bench
`default_nettype wire
